// ---- src/rtpp_consts.svh ----
// Purpose: offsets, field positions and reset values of the buffer selector
// Assumes: byte addresses on a 32-bit AXI4-Lite slave, one word per register
// Notes: the behaviour list below names each tag used in the design
//
// Behaviour
// - suspend seen, clear acknowledge bit
// - while stopped, reuse active buffer only
// - select 1 means next buffer B
// - suspend cleared, set acknowledge, resume alternation
// - good message flips the select bit
// - separate storage sends broadcasts to broadcast buffer
// - single broadcast buffer, always overwritten
// - broadcast transmit in separate storage updates words, sends nothing
// - broadcast completion in separate storage never flips select bit
// - broadcast interrupt when both enables set
// - combined storage treats broadcast like normal message
// - accessed interrupt when both enables set
// - reset clears every select bit
// - non-broadcast message clears broadcast flag
// - double buffering unsuspended sets acknowledge bit
// - suppress option blocks flips after bad messages
`ifndef RTPP_CONSTS_SVH
`define RTPP_CONSTS_SVH
`define OFS_CFG 4'h0
`define OFS_IRQEN 4'h4
`define OFS_STATUS 4'h8
`define CFG_SEP_BIT 0
`define CFG_BCINV_BIT 1
`define CFG_TSUP_BIT 2
`define CFG_RST 3'h0
`define IRQEN_IBR_BIT 0
`define IRQEN_IWA_BIT 1
`define IRQEN_RST 2'h0
`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3
`endif

// ---- src/rtpp_pkg.sv ----
// Purpose: types shared by the buffer selector and its bench
// Assumes: nothing
// Notes: ctrl fields mirror the descriptor control word bits used here
package rtpp_pkg;
	// buffer a message is routed to
	typedef enum logic [1:0] {BUF_A, BUF_B, BUF_BROADCAST_FLAG} buf_id_t;
	// descriptor control word bits sampled at message start
	typedef struct packed {
		logic message_accessed_irq;
		logic broadcast_received_irq;
		logic alternation_suspend;
		logic double_buffer_select;
	} ctrl_in_t;
	// completion status of a message
	typedef struct packed {
		logic incomplete;
		logic illegal;
		logic busy;
		logic msg_error;
	} msg_status_t;
	// bits written back to the control word
	typedef struct packed {
		logic alternation_active_ack;
		logic buffer_select;
	} ctrl_wb_t;
	// message tracking states
	typedef enum {ST_IDLE, ST_MSG} msg_state_t;
endpackage

// ---- src/rt_pingpong_buffer_select.sv ----
// Purpose: per-subaddress double buffer selection with stop handshake
// Assumes: message engine on aclk gives start and end pulses
// Notes: select bits are shadowed here and written back via wb_valid
`timescale 1ns/1ns
`include "rtpp_consts.svh"
module rt_pingpong_buffer_select #(
	parameter int NUM_SA = 64,
	parameter int SA_W = 6
) (
	// clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// axi4-lite write
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// message engine
	input wire logic msg_start,
	input wire logic [SA_W-1:0] msg_sa,
	input wire logic msg_broadcast,
	input wire logic msg_transmit,
	input wire rtpp_pkg::ctrl_in_t msg_ctrl,
	input wire logic msg_end,
	input wire rtpp_pkg::msg_status_t msg_status,
	// routing and write-back
	output rtpp_pkg::buf_id_t buf_sel,
	output logic tx_data_inhibit,
	output logic wb_valid,
	output logic [SA_W-1:0] wb_sa,
	output rtpp_pkg::ctrl_wb_t wb_ctrl,
	output logic miw_broadcast_flag,
	output logic irq
);
	// select bit to buffer: 1 means last used A, so B is next
	function automatic rtpp_pkg::buf_id_t sel_buf(input logic sel);
		sel_buf = sel ? rtpp_pkg::BUF_B : rtpp_pkg::BUF_A;
	endfunction
	// may this status flip the select bit
	function automatic logic good_msg(input rtpp_pkg::msg_status_t s, input logic tsup);
		if (tsup) begin
			good_msg = !(s.incomplete | s.illegal | s.busy | s.msg_error);
		end else begin
			good_msg = !(s.incomplete | s.msg_error);
		end
	endfunction

	// message tracking state
	rtpp_pkg::msg_state_t state_r, state_nxt;
	logic [SA_W-1:0] cur_sa_r, cur_sa_nxt; // subaddress in flight
	logic cur_bc_r, cur_bc_nxt; // message is broadcast
	logic cur_sel_r, cur_sel_nxt; // select bit seen at start
	rtpp_pkg::ctrl_in_t cur_ctrl_r, cur_ctrl_nxt; // control bits seen at start
	logic sel_mem_r [NUM_SA]; // shadow select bit per subaddress
	logic sel_mem_nxt [NUM_SA];
	rtpp_pkg::buf_id_t buf_sel_r, buf_sel_nxt;
	logic inhibit_r, inhibit_nxt;
	logic wb_valid_r, wb_valid_nxt;
	logic [SA_W-1:0] wb_sa_r, wb_sa_nxt;
	rtpp_pkg::ctrl_wb_t wb_ctrl_r, wb_ctrl_nxt;
	logic miw_r, miw_nxt;
	logic irq_r, irq_nxt;
	// software registers
	logic [2:0] cfg_r, cfg_nxt;
	logic [1:0] irqen_r, irqen_nxt;
	// axi holding state
	logic aw_hold_r, aw_hold_nxt;
	logic [3:0] awaddr_r, awaddr_nxt;
	logic w_hold_r, w_hold_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;

	// decoded helpers
	logic sep_on; // separate broadcast storage in force
	logic start_ev; // message accepted this cycle
	logic end_ev; // message completes this cycle
	logic start_sel; // stored select of the starting subaddress
	logic toggle; // select flips at this completion
	assign sep_on = cfg_r[`CFG_SEP_BIT] & !cfg_r[`CFG_BCINV_BIT];
	assign start_ev = ce & (state_r == rtpp_pkg::ST_IDLE) & msg_start;
	assign end_ev = ce & (state_r == rtpp_pkg::ST_MSG) & msg_end;
	assign start_sel = sel_mem_r[msg_sa];
	// alternation only when active and not a separated broadcast
	assign toggle = cur_ctrl_r.double_buffer_select & !cur_ctrl_r.alternation_suspend
		& !(cur_bc_r & sep_on) & good_msg(msg_status, cfg_r[`CFG_TSUP_BIT]);

	// message path next state
	always_comb begin
		state_nxt = state_r;
		cur_sa_nxt = cur_sa_r;
		cur_bc_nxt = cur_bc_r;
		cur_sel_nxt = cur_sel_r;
		cur_ctrl_nxt = cur_ctrl_r;
		sel_mem_nxt = sel_mem_r;
		buf_sel_nxt = buf_sel_r;
		inhibit_nxt = inhibit_r;
		wb_valid_nxt = 1'b0;
		wb_sa_nxt = wb_sa_r;
		wb_ctrl_nxt = wb_ctrl_r;
		miw_nxt = miw_r;
		irq_nxt = 1'b0;
		case (state_r)
			rtpp_pkg::ST_IDLE: begin
				// sample control word and select bit at start
				if (msg_start) begin
					state_nxt = rtpp_pkg::ST_MSG;
					cur_sa_nxt = msg_sa;
					cur_bc_nxt = msg_broadcast;
					cur_sel_nxt = start_sel;
					cur_ctrl_nxt = msg_ctrl;
					if (msg_broadcast & sep_on) begin
						// one broadcast buffer, no alternation
						buf_sel_nxt = rtpp_pkg::BUF_BROADCAST_FLAG;
						inhibit_nxt = msg_transmit;
					end else if (msg_ctrl.double_buffer_select) begin
						// suspended or not, the select bit names the active one
						buf_sel_nxt = sel_buf(start_sel);
						inhibit_nxt = 1'b0;
					end else begin
						buf_sel_nxt = rtpp_pkg::BUF_A;
						inhibit_nxt = 1'b0;
					end
				end
			end
			rtpp_pkg::ST_MSG: begin
				// post-processing writes back ack and select
				if (msg_end) begin
					state_nxt = rtpp_pkg::ST_IDLE;
					sel_mem_nxt[cur_sa_r] = cur_sel_r ^ toggle;
					wb_valid_nxt = 1'b1;
					wb_sa_nxt = cur_sa_r;
					wb_ctrl_nxt.buffer_select = cur_sel_r ^ toggle;
					// ack low while suspended, high while alternating
					wb_ctrl_nxt.alternation_active_ack = cur_ctrl_r.double_buffer_select
						& !cur_ctrl_r.alternation_suspend;
					miw_nxt = cur_bc_r;
					irq_nxt = (cur_bc_r & cur_ctrl_r.broadcast_received_irq
						& irqen_r[`IRQEN_IBR_BIT])
						| (cur_ctrl_r.message_accessed_irq
						& irqen_r[`IRQEN_IWA_BIT]);
				end
			end
			default: begin
				state_nxt = rtpp_pkg::ST_IDLE;
			end
		endcase
	end

	// axi ready terms: gated by ce so nothing is taken while frozen
	logic aw_got, w_got, do_wr;
	logic [3:0] wr_addr;
	assign awready = ce & !aw_hold_r & !bvalid_r;
	assign wready = ce & !w_hold_r & !bvalid_r;
	assign arready = ce & !rvalid_r;
	assign aw_got = aw_hold_r | (awvalid & awready);
	assign w_got = w_hold_r | (wvalid & wready);
	assign do_wr = aw_got & w_got;
	assign wr_addr = aw_hold_r ? awaddr_r : awaddr;

	// register bus next state
	always_comb begin
		logic [31:0] wd;
		logic [3:0] ws;
		wd = w_hold_r ? wdata_r : wdata;
		ws = w_hold_r ? wstrb_r : wstrb;
		cfg_nxt = cfg_r;
		irqen_nxt = irqen_r;
		aw_hold_nxt = aw_hold_r;
		awaddr_nxt = awaddr_r;
		w_hold_nxt = w_hold_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r & !bready;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r & !rready;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		// address and data may arrive in either order
		if (awvalid & awready) begin
			aw_hold_nxt = 1'b1;
			awaddr_nxt = awaddr;
		end
		if (wvalid & wready) begin
			w_hold_nxt = 1'b1;
			wdata_nxt = wdata;
			wstrb_nxt = wstrb;
		end
		if (do_wr) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = `RESP_OKAY;
			case (wr_addr)
				`OFS_CFG: begin
					if (ws[0]) begin
						cfg_nxt = wd[2:0];
					end
				end
				`OFS_IRQEN: begin
					if (ws[0]) begin
						irqen_nxt = wd[1:0];
					end
				end
				`OFS_STATUS: begin
					// read-only, write ignored
				end
				default: begin
					bresp_nxt = `RESP_DECERR;
				end
			endcase
		end
		// reads answer from live state
		if (arvalid & arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = `RESP_OKAY;
			case (araddr)
				`OFS_CFG: rdata_nxt = {29'h0, cfg_r};
				`OFS_IRQEN: rdata_nxt = {30'h0, irqen_r};
				`OFS_STATUS: rdata_nxt = {27'h0, buf_sel_r, wb_ctrl_r,
					state_r == rtpp_pkg::ST_MSG};
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = `RESP_DECERR;
				end
			endcase
		end
	end

	// all state: synchronous reset, frozen while ce is low
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= rtpp_pkg::ST_IDLE;
			cur_sa_r <= '0;
			cur_bc_r <= 1'b0;
			cur_sel_r <= 1'b0;
			cur_ctrl_r <= '0;
			for (int i = 0; i < NUM_SA; i++) begin
				sel_mem_r[i] <= 1'b0;
			end
			buf_sel_r <= rtpp_pkg::BUF_A;
			inhibit_r <= 1'b0;
			wb_valid_r <= 1'b0;
			wb_sa_r <= '0;
			wb_ctrl_r <= '0;
			miw_r <= 1'b0;
			irq_r <= 1'b0;
			cfg_r <= `CFG_RST;
			irqen_r <= `IRQEN_RST;
			aw_hold_r <= 1'b0;
			awaddr_r <= 4'h0;
			w_hold_r <= 1'b0;
			wdata_r <= 32'h0;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= `RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0;
			rresp_r <= `RESP_OKAY;
		end else if (ce) begin
			state_r <= state_nxt;
			cur_sa_r <= cur_sa_nxt;
			cur_bc_r <= cur_bc_nxt;
			cur_sel_r <= cur_sel_nxt;
			cur_ctrl_r <= cur_ctrl_nxt;
			sel_mem_r <= sel_mem_nxt;
			buf_sel_r <= buf_sel_nxt;
			inhibit_r <= inhibit_nxt;
			wb_valid_r <= wb_valid_nxt;
			wb_sa_r <= wb_sa_nxt;
			wb_ctrl_r <= wb_ctrl_nxt;
			miw_r <= miw_nxt;
			irq_r <= irq_nxt;
			cfg_r <= cfg_nxt;
			irqen_r <= irqen_nxt;
			aw_hold_r <= aw_hold_nxt;
			awaddr_r <= awaddr_nxt;
			w_hold_r <= w_hold_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

	// outputs straight from flops
	assign buf_sel = buf_sel_r;
	assign tx_data_inhibit = inhibit_r;
	assign wb_valid = wb_valid_r;
	assign wb_sa = wb_sa_r;
	assign wb_ctrl = wb_ctrl_r;
	assign miw_broadcast_flag = miw_r;
	assign irq = irq_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;

	// checks on the selection and write-back
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	suspend_ack_a: assert property (end_ev & cur_ctrl_r.alternation_suspend
		|=> wb_valid & !wb_ctrl.alternation_active_ack)
		else $error("ack not cleared while suspended");
	frozen_sel_a: assert property (end_ev & cur_ctrl_r.alternation_suspend
		|=> wb_ctrl.buffer_select == $past(cur_sel_r))
		else $error("select moved while suspended");
	sel_map_a: assert property (start_ev & msg_ctrl.double_buffer_select
		& !(msg_broadcast & sep_on) |=> buf_sel == sel_buf($past(start_sel)))
		else $error("wrong buffer for select bit");
	resume_ack_a: assert property (end_ev & cur_ctrl_r.double_buffer_select
		& !cur_ctrl_r.alternation_suspend |=> wb_ctrl.alternation_active_ack)
		else $error("ack not set while alternating");
	good_toggle_a: assert property (end_ev & toggle
		|=> wb_ctrl.buffer_select != $past(cur_sel_r) ##1 !wb_valid)
		else $error("select not flipped after good message");
	broadcast_flag_route_a: assert property (start_ev & msg_broadcast & sep_on
		|=> buf_sel == rtpp_pkg::BUF_BROADCAST_FLAG && tx_data_inhibit == $past(msg_transmit))
		else $error("broadcast not routed to broadcast buffer");
	broadcast_flag_keep_a: assert property (end_ev & cur_bc_r & sep_on
		|=> wb_ctrl.buffer_select == $past(cur_sel_r))
		else $error("broadcast flipped select");
	broadcast_flag_irq_a: assert property (end_ev & cur_bc_r & cur_ctrl_r.broadcast_received_irq
		& irqen_r[`IRQEN_IBR_BIT] |=> irq ##1 !irq)
		else $error("broadcast interrupt missing");
	access_irq_a: assert property (end_ev & cur_ctrl_r.message_accessed_irq
		& irqen_r[`IRQEN_IWA_BIT] |=> irq)
		else $error("accessed interrupt missing");
	miw_flag_a: assert property (end_ev |=> miw_broadcast_flag == $past(cur_bc_r))
		else $error("broadcast flag wrong");
	suppress_a: assert property (end_ev & cfg_r[`CFG_TSUP_BIT]
		& (msg_status.busy | msg_status.illegal) |=> wb_ctrl.buffer_select == $past(cur_sel_r))
		else $error("select flipped after bad message");
	broadcast_flag_cov_c: cover property (start_ev & msg_broadcast & sep_on ##[1:20] end_ev);
	suspend_cov_c: cover property (end_ev & cur_ctrl_r.alternation_suspend);
	pingpong_cov_c: cover property (end_ev & toggle ##[1:40] end_ev & toggle);
endmodule

// ---- test/rtpp_host_model.sv ----
// Purpose: host side copy of the descriptor control words of every subaddress
// Assumes: write-backs arrive as one-cycle wb_valid pulses on aclk
// Notes: the bench asks it only for ack, after suspend and after resume
`timescale 1ns/1ns
module rtpp_host_model (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write-back from the selector
	input wire logic wb_valid,
	input wire logic [5:0] wb_sa,
	input wire rtpp_pkg::ctrl_wb_t wb_ctrl,
	// lookup of one descriptor
	input wire logic [5:0] q_sa,
	output logic q_ack,
	output logic q_sel
);
	// shared ram words, one ack and select pair per subaddress
	rtpp_pkg::ctrl_wb_t word_r [64];
	// ram is cleared by reset, so buffer a is used first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 64; i++) word_r[i] <= 2'h0;
		end else if (wb_valid) begin
			word_r[wb_sa] <= wb_ctrl;
		end
	end
	// host only services once ack reads low, and before a second message
	assign q_ack = word_r[q_sa].alternation_active_ack;
	assign q_sel = word_r[q_sa].buffer_select;
endmodule

// ---- test/testbench.sv ----
// Purpose: self-checking bench for the ping-pong buffer selector
// Assumes: ce held high except for one frozen cycle near the end, host model mirrors descriptor words
// Notes: expectations queue at the driver, checked when wb_valid shows
`timescale 1ns/1ns
`include "rtpp_consts.svh"
module testbench;
	// expected write-back of one message
	typedef struct packed {
		rtpp_pkg::buf_id_t b;
		logic tdi;
		logic [5:0] sa;
		rtpp_pkg::ctrl_wb_t w;
		logic message_info_word;
		logic irq;
	} exp_t;
	logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp;
	logic msg_start = 1'b0, msg_end = 1'b0, msg_broadcast = 1'b0, msg_transmit = 1'b0;
	logic [5:0] msg_sa = 6'h0, wb_sa, q_sa = 6'h5;
	rtpp_pkg::ctrl_in_t msg_ctrl = 4'h0;
	rtpp_pkg::msg_status_t msg_status = 4'h0;
	rtpp_pkg::buf_id_t buf_sel;
	rtpp_pkg::ctrl_wb_t wb_ctrl;
	logic tx_data_inhibit, wb_valid, miw_broadcast_flag, irq, q_ack, q_sel;
	// bench state
	int num_errors = 0, checked = 0, cyc = 0, seed = 1307;
	exp_t expq[$], mon_e, last_e;
	logic sel_m [64];
	logic [2:0] cfg_m = 3'h0;
	logic [1:0] en_m = 2'h0;
	logic [31:0] r;

	always #4 aclk = ~aclk;

	rt_pingpong_buffer_select rt_pingpong_buffer_select_inst (.aclk(aclk), .aresetn(aresetn),
		.ce(ce), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
		.wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
		.rresp(rresp), .rvalid(rvalid), .rready(rready), .msg_start(msg_start),
		.msg_sa(msg_sa), .msg_broadcast(msg_broadcast), .msg_transmit(msg_transmit),
		.msg_ctrl(msg_ctrl), .msg_end(msg_end), .msg_status(msg_status), .buf_sel(buf_sel),
		.tx_data_inhibit(tx_data_inhibit), .wb_valid(wb_valid), .wb_sa(wb_sa),
		.wb_ctrl(wb_ctrl), .miw_broadcast_flag(miw_broadcast_flag), .irq(irq));
	rtpp_host_model rtpp_host_model_inst (.aclk(aclk), .aresetn(aresetn), .wb_valid(wb_valid),
		.wb_sa(wb_sa), .wb_ctrl(wb_ctrl), .q_sa(q_sa), .q_ack(q_ack), .q_sel(q_sel));

	// one comparison, counted
	task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		checked++;
		if (got !== ex) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// counts, verdict, end of run
	task automatic give_verdict();
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// axi write: address and data offered together, each released once taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		logic ta, tw, tb;
		logic [1:0] br;
		tb = 1'b0;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		while (!tb) begin
			@(negedge aclk);
			ta = awvalid && awready; tw = wvalid && wready; tb = bvalid; br = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		chk("bresp", er, br);
	endtask

	// axi read: ar held until taken, rready held until rvalid
	task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ta, tr;
		logic [31:0] d;
		logic [1:0] rr;
		tr = 1'b0;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		while (!tr) begin
			@(negedge aclk);
			ta = arvalid && arready; tr = rvalid; d = rdata; rr = rresp;
			@(posedge aclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
		chk("rresp", er, rr);
		chk("rdata", ed, d);
	endtask

	// one message: note the expectation, then start and end pulses
	task automatic msg(input logic [5:0] sa, input logic bc, input logic tx,
			input rtpp_pkg::ctrl_in_t c, input rtpp_pkg::msg_status_t s);
		exp_t e;
		logic sep, good;
		sep = cfg_m[0] && !cfg_m[1];
		good = !s.incomplete && !s.msg_error && !(cfg_m[2] && (s.illegal || s.busy));
		e.b = (bc && sep) ? rtpp_pkg::BUF_BROADCAST_FLAG :
			(c.double_buffer_select && sel_m[sa]) ? rtpp_pkg::BUF_B : rtpp_pkg::BUF_A;
		if (c.double_buffer_select && !c.alternation_suspend && !(bc && sep) && good)
			sel_m[sa] = ~sel_m[sa];
		e.w = {c.double_buffer_select && !c.alternation_suspend, sel_m[sa]};
		e.tdi = bc && tx && sep;
		e.sa = sa; e.message_info_word = bc;
		e.irq = (bc && c.broadcast_received_irq && en_m[0]) || (c.message_accessed_irq && en_m[1]);
		expq.push_back(e);
		last_e = e;
		@(posedge aclk);
		msg_start <= 1'b1; msg_sa <= sa; msg_broadcast <= bc; msg_transmit <= tx; msg_ctrl <= c;
		@(posedge aclk);
		msg_start <= 1'b0; msg_end <= 1'b1; msg_status <= s;
		@(posedge aclk);
		msg_end <= 1'b0;
	endtask

	// result watcher: oldest note against the write-back
	always @(negedge aclk) begin
		if (wb_valid) begin
			if (expq.size() == 0) chk("unexpected write-back", 32'h0, 32'h1);
			else begin
				mon_e = expq.pop_front();
				chk("buf_sel", mon_e.b, buf_sel);
				chk("tx_data_inhibit", mon_e.tdi, tx_data_inhibit);
				chk("wb_sa", mon_e.sa, wb_sa);
				chk("wb_ctrl", mon_e.w, wb_ctrl);
				chk("miw_broadcast_flag", mon_e.message_info_word, miw_broadcast_flag);
				chk("irq", mon_e.irq, irq);
			end
		end else if (irq) chk("irq without write-back", 32'h0, 32'h1);
	end

	// hang guard, generous for about 370 cycles of traffic
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			give_verdict();
		end
	end

	// set both config registers and the model copies
	task automatic setup(input logic [2:0] c, input logic [1:0] en);
		cfg_m = c; en_m = en;
		axw(`OFS_CFG, {29'h0, c}, `RESP_OKAY);
		axw(`OFS_IRQEN, {30'h0, en}, `RESP_OKAY);
	endtask

	initial begin
		foreach (sel_m[i]) sel_m[i] = 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		axr(`OFS_CFG, 32'h0, `RESP_OKAY);
		axr(4'hc, 32'h0, `RESP_DECERR);
		axw(4'hc, 32'h1, `RESP_DECERR);
		axw(`OFS_STATUS, 32'h1f, `RESP_OKAY);
		setup(3'h1, 2'h3);
		// alternation, suspend, resume on one subaddress
		msg(6'h5, 1'b0, 1'b0, 4'h1, 4'h0);
		msg(6'h5, 1'b0, 1'b0, 4'h1, 4'h0);
		msg(6'h5, 1'b0, 1'b0, 4'h3, 4'h0);
		repeat (2) @(posedge aclk);
		chk("ack after suspend", 32'h0, q_ack);
		msg(6'h5, 1'b0, 1'b0, 4'h3, 4'h0);
		msg(6'h5, 1'b0, 1'b0, 4'h1, 4'h0);
		repeat (2) @(posedge aclk);
		chk("ack after resume", 32'h1, q_ack);
		axr(`OFS_STATUS, {27'h0, last_e.b, last_e.w, 1'b0}, `RESP_OKAY);
		// broadcasts in separate and combined storage
		msg(6'h5, 1'b1, 1'b1, 4'h5, 4'h0);
		msg(6'h5, 1'b0, 1'b0, 4'h9, 4'h0);
		setup(3'h0, 2'h1);
		msg(6'h5, 1'b1, 1'b0, 4'h5, 4'h0);
		setup(3'h3, 2'h2);
		msg(6'h5, 1'b1, 1'b1, 4'h9, 4'h0);
		// random traffic over a few subaddresses
		for (int i = 0; i < 80; i++) begin
			if (i % 16 == 0) begin
				r = $random(seed);
				setup(r[2:0], r[4:3]);
			end
			r = $random(seed);
			msg({4'h0, r[1:0]}, r[2], r[3], r[7:4], (r[10:8] == 3'h0) ? r[14:11] : 4'h0);
		end
		// second reset in mid-run clears select bits and config
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (sel_m[i]) sel_m[i] = 1'b0;
		cfg_m = 3'h0; en_m = 2'h0;
		axr(`OFS_CFG, 32'h0, `RESP_OKAY);
		// clock enable low must refuse every register request
		@(posedge aclk);
		ce <= 1'b0;
		@(negedge aclk);
		chk("awready frozen", 32'h0, awready);
		chk("arready frozen", 32'h0, arready);
		@(posedge aclk);
		ce <= 1'b1;
		for (int i = 0; i < 4; i++) msg(i[5:0], 1'b0, 1'b0, 4'h1, 4'h0);
		repeat (4) @(posedge aclk);
		chk("pending notes", 32'h0, expq.size());
		give_verdict();
	end
endmodule
